//--- rtl/eeu_pkg.sv
// Shared constants, register map and state encoding of the exception entry and exit unit.
// Assumes a 32-bit core whose register file is reached by a frame slot index.
package eeu_pkg;
	localparam int EXC_NUM_DEF = 48;
	localparam int ADDR_W = 12;
	localparam int PRI_BITS = 3;
	localparam int PRI_W = 8;
	localparam int GROUP_W = 3;
	localparam int KEY_W = 10;
	localparam int FAULT_N = 3;
	localparam logic [PRI_W-PRI_BITS-1:0] PRI_PAD = 5'h00;
	localparam logic [PRI_W-1:0] PRE_MASK_BASE = 8'hFE;
	localparam logic [1:0] CLS_NMI = 2'h0;
	localparam logic [1:0] CLS_HARD = 2'h1;
	localparam logic [1:0] CLS_CFG = 2'h2;
	localparam int EXC_NMI = 2;
	localparam int EXC_HARD = 3;
	localparam int EXC_MEM = 4;
	localparam int EXC_FIRST_CFG = 4;
	localparam int EXC_FIRST_REQ = 2;
	localparam int WORD_BYTES = 4;
	localparam logic [31:0] FRAME_BYTES = 32'h0000_0020;
	localparam logic [2:0] FRAME_FIRST = 3'h0;
	localparam logic [2:0] FRAME_LAST = 3'h7;
	localparam logic [31:0] VTOR_RESET = 32'h0000_0000;
	localparam logic [31:0] VEC_SP_OFF = 32'h0000_0000;
	localparam logic [31:0] VEC_RESET_OFF = 32'h0000_0004;
	localparam logic [31:0] VEC_EXT_OFF = 32'h0000_0040;
	// Frame slots: the slot is also the word offset of the register inside the frame.
	localparam logic [2:0] SLOT_R0 = 3'h0;
	localparam logic [2:0] SLOT_R1 = 3'h1;
	localparam logic [2:0] SLOT_R2 = 3'h2;
	localparam logic [2:0] SLOT_R3 = 3'h3;
	localparam logic [2:0] SLOT_R12 = 3'h4;
	localparam logic [2:0] SLOT_LINK = 3'h5;
	localparam logic [2:0] SLOT_PC = 3'h6;
	localparam logic [2:0] SLOT_PSW = 3'h7;
	localparam logic [ADDR_W-1:0] OFF_CTRL = 12'h000;
	localparam logic [ADDR_W-1:0] OFF_VTOR = 12'h004;
	localparam logic [ADDR_W-1:0] OFF_STAT = 12'h008;
	localparam logic [ADDR_W-1:0] OFF_MSP = 12'h00C;
	localparam logic [ADDR_W-1:0] OFF_PSP = 12'h010;
	localparam logic [ADDR_W-1:0] OFF_PRI = 12'h100;
	localparam int CTRL_FEN_LSB = 4;

	typedef enum logic [2:0] {
		ST_BOOT_SP = 3'b000,
		ST_BOOT_PC = 3'b001,
		ST_RUN = 3'b010,
		ST_STACK = 3'b011,
		ST_VECTOR = 3'b100,
		ST_UNSTACK = 3'b101
	} eeu_state_t;

	function automatic logic [2:0] eeu_push_slot(input logic [2:0] step);
		case (step)
			3'h0: eeu_push_slot = SLOT_PC;
			3'h1: eeu_push_slot = SLOT_PSW;
			3'h2: eeu_push_slot = SLOT_R0;
			3'h3: eeu_push_slot = SLOT_R1;
			3'h4: eeu_push_slot = SLOT_R2;
			3'h5: eeu_push_slot = SLOT_R3;
			3'h6: eeu_push_slot = SLOT_R12;
			default: eeu_push_slot = SLOT_LINK;
		endcase
	endfunction : eeu_push_slot
endpackage : eeu_pkg

//--- rtl/eeu_prio_key.sv
// Priority key of one exception: class, grouped pre-emption part and full priority.
// Assumes the grouping setting is shared by all exceptions.
module eeu_prio_key #(
	parameter int NUM = 4
) (
	input wire logic [eeu_pkg::PRI_BITS-1:0] pri_field,
	input wire logic [eeu_pkg::GROUP_W-1:0] group,
	output logic [eeu_pkg::KEY_W-1:0] pre_key,
	output logic [eeu_pkg::KEY_W-1:0] full_key
);
	import eeu_pkg::*;

	localparam logic [1:0] CLS = (NUM == EXC_NMI) ? CLS_NMI :
		(NUM == EXC_HARD) ? CLS_HARD : CLS_CFG;

	// Fixed-priority exceptions sit below every configurable value through their class.
	wire logic [PRI_W-1:0] pri8 = (CLS == CLS_CFG) ? {pri_field, PRI_PAD} : '0;
	wire logic [PRI_W-1:0] pre_mask = PRE_MASK_BASE << group;

	assign pre_key = {CLS, pri8 & pre_mask};
	assign full_key = {CLS, pri8};
endmodule : eeu_prio_key

//--- rtl/eeu_core.sv
// Exception entry and exit sequencer with its APB register file.
// Assumes the core stalls while core_stall is high and answers register reads at once.
//
// The APB slave port and the address map were chosen for this implementation.
module eeu_core #(
	parameter int NUM_EXC = eeu_pkg::EXC_NUM_DEF
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [eeu_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [NUM_EXC-1:0] exc_req,
	input wire logic exc_return,
	input wire logic exc_return_psp,
	output logic [2:0] core_reg_idx,
	input wire logic [31:0] core_reg_rdata,
	output logic core_reg_we,
	output logic [31:0] core_reg_wdata,
	output logic core_stall,
	output logic mem_req,
	output logic mem_we,
	output logic [31:0] mem_addr,
	output logic [31:0] mem_wdata,
	input wire logic [31:0] mem_rdata,
	input wire logic mem_ready,
	output logic handler_start,
	output logic [31:0] handler_pc,
	output logic ctx_resume,
	output logic handler_mode,
	output logic [$clog2(NUM_EXC)-1:0] active_exc,
	output logic sp_use_process,
	output logic [31:0] active_sp
);
	import eeu_pkg::*;

	localparam int NW = $clog2(NUM_EXC);

	eeu_state_t state_reg, state_next;
	logic [GROUP_W-1:0] group_reg;
	logic [FAULT_N-1:0] fault_en_reg;
	logic [31:0] vtor_reg;
	logic [PRI_BITS-1:0] pri_reg [NUM_EXC];
	logic [31:0] msp_reg, msp_next, psp_reg, psp_next, frame_reg, frame_next;
	logic [31:0] hpc_reg, hpc_next, prdata_reg;
	logic [NW-1:0] cur_reg, cur_next, target_reg, target_next;
	logic [NUM_EXC-1:0] active_reg, active_next;
	logic [2:0] step_reg, step_next;
	logic sp_sel_reg, sp_sel_next, hmode_reg, hmode_next, ret_psp_reg, ret_psp_next;
	logic ret_thr_reg, ret_thr_next, hstart_reg, hstart_next, resume_reg, resume_next;

	////////////////////////////////////////////////////////////////////////////////
	// APB decode. Reads are captured in the setup phase so pready can stay high.

	wire logic setup_ph = psel && !penable;
	wire logic aligned = (paddr[1:0] == 2'h0);
	wire logic [ADDR_W-1:0] pri_off = paddr - OFF_PRI;
	wire logic [NW-1:0] pri_idx = pri_off[NW+1:2];
	wire logic hit_ctrl = aligned && (paddr == OFF_CTRL);
	wire logic hit_vtor = aligned && (paddr == OFF_VTOR);
	wire logic hit_stat = aligned && (paddr == OFF_STAT);
	wire logic hit_msp = aligned && (paddr == OFF_MSP);
	wire logic hit_psp = aligned && (paddr == OFF_PSP);
	wire logic hit_pri = aligned && (paddr >= OFF_PRI)
		&& (pri_off[ADDR_W-1:2] < (ADDR_W-2)'(NUM_EXC));
	wire logic hit_any = hit_ctrl || hit_vtor || hit_stat || hit_msp || hit_psp || hit_pri;
	wire logic wr_en = psel && penable && pwrite && hit_any;
	wire logic [31:0] ctrl_word = 32'({fault_en_reg, 1'b0, group_reg});
	wire logic [31:0] stat_word = 32'({state_reg, sp_sel_reg, hmode_reg, 16'(cur_reg)});
	wire logic [31:0] pri_word = 32'({pri_reg[pri_idx], PRI_PAD});
	wire logic [31:0] rd_mux = hit_ctrl ? ctrl_word : hit_vtor ? vtor_reg :
		hit_stat ? stat_word : hit_msp ? msp_reg : hit_psp ? psp_reg :
		hit_pri ? pri_word : 32'h0000_0000;

	assign prdata = prdata_reg;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !hit_any;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_reg <= 32'h0000_0000;
			group_reg <= '0;
			fault_en_reg <= '0;
			vtor_reg <= VTOR_RESET;
		end else begin
			if (setup_ph && !pwrite)
				prdata_reg <= rd_mux;
			if (wr_en && hit_ctrl) begin
				group_reg <= pwdata[GROUP_W-1:0];
				fault_en_reg <= pwdata[CTRL_FEN_LSB +: FAULT_N];
			end
			if (wr_en && hit_vtor)
				vtor_reg <= pwdata;
		end
	end

	// Only the implemented upper bits are stored; fixed-priority numbers ignore writes.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < NUM_EXC; i++)
				pri_reg[i] <= '0;
		end else if (wr_en && hit_pri && (pri_idx >= NW'(EXC_FIRST_CFG))) begin
			pri_reg[pri_idx] <= pwdata[PRI_W-1 -: PRI_BITS];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Priority keys and arbitration.

	logic [KEY_W-1:0] pre_key [NUM_EXC];
	logic [KEY_W-1:0] full_key [NUM_EXC];

	for (genvar g = 0; g < NUM_EXC; g++) begin : g_key
		eeu_prio_key #(.NUM(g)) u_key (
			.pri_field(pri_reg[g]),
			.group(group_reg),
			.pre_key(pre_key[g]),
			.full_key(full_key[g])
		);
	end

	logic [NUM_EXC-1:0] eff_req;
	logic [NW-1:0] best_num;
	logic [KEY_W-1:0] best_full, best_stk_pre;
	logic pend_any, stk_any;

	always_comb begin
		eff_req = exc_req;
		for (int k = 0; k < EXC_FIRST_REQ; k++)
			eff_req[k] = 1'b0;
		for (int k = 0; k < FAULT_N; k++) begin
			if (exc_req[EXC_MEM+k] && !fault_en_reg[k]) begin
				eff_req[EXC_MEM+k] = 1'b0;
				eff_req[EXC_HARD] = 1'b1;
			end
		end
	end

	// An already active exception is not pending again until its handler returns.
	wire logic [NUM_EXC-1:0] pend = eff_req & ~active_reg;

	always_comb begin
		pend_any = 1'b0;
		best_num = '0;
		best_full = '0;
		stk_any = 1'b0;
		best_stk_pre = '0;
		for (int i = 0; i < NUM_EXC; i++) begin
			// Strict compare keeps the smaller number on equal priority.
			if (pend[i] && (!pend_any || full_key[i] < best_full)) begin
				pend_any = 1'b1;
				best_num = NW'(i);
				best_full = full_key[i];
			end
			if (active_reg[i] && NW'(i) != cur_reg && (!stk_any || pre_key[i] < best_stk_pre)) begin
				stk_any = 1'b1;
				best_stk_pre = pre_key[i];
			end
		end
	end

	wire logic [KEY_W-1:0] best_pre = pre_key[best_num];
	wire logic preempt_go = pend_any && (!hmode_reg || best_pre < pre_key[cur_reg]);
	wire logic late_go = pend_any && (best_pre < pre_key[target_reg]);
	wire logic tail_go = pend_any && (!stk_any || best_pre < best_stk_pre);
	wire logic ret_go = exc_return && hmode_reg;
	wire logic [31:0] cur_sp = sp_sel_reg ? psp_reg : msp_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Memory and core register side.

	wire logic [2:0] slot = (state_reg == ST_STACK) ? eeu_push_slot(step_reg) : step_reg;
	wire logic last_word = (step_reg == FRAME_LAST);
	wire logic [31:0] vec_addr = vtor_reg + 32'(target_reg) * WORD_BYTES;

	assign mem_req = (state_reg != ST_RUN);
	assign mem_we = (state_reg == ST_STACK);
	assign mem_addr = (state_reg == ST_BOOT_SP) ? VTOR_RESET + VEC_SP_OFF :
		(state_reg == ST_BOOT_PC) ? VTOR_RESET + VEC_RESET_OFF :
		(state_reg == ST_VECTOR) ? vec_addr : frame_reg + 32'(slot) * WORD_BYTES;
	assign mem_wdata = core_reg_rdata;
	assign core_reg_idx = slot;
	assign core_reg_we = (state_reg == ST_UNSTACK) && mem_ready;
	assign core_reg_wdata = mem_rdata;
	assign core_stall = (state_reg != ST_RUN);
	assign handler_start = hstart_reg;
	assign handler_pc = hpc_reg;
	assign ctx_resume = resume_reg;
	assign handler_mode = hmode_reg;
	assign active_exc = cur_reg;
	assign sp_use_process = sp_sel_reg;
	assign active_sp = cur_sp;

	////////////////////////////////////////////////////////////////////////////////
	// Sequencer.

	always_comb begin
		state_next = state_reg;
		msp_next = msp_reg;
		psp_next = (wr_en && hit_psp) ? pwdata : psp_reg;
		frame_next = frame_reg;
		hpc_next = hpc_reg;
		cur_next = cur_reg;
		target_next = target_reg;
		active_next = active_reg;
		step_next = step_reg;
		sp_sel_next = sp_sel_reg;
		hmode_next = hmode_reg;
		ret_psp_next = ret_psp_reg;
		ret_thr_next = ret_thr_reg;
		hstart_next = 1'b0;
		resume_next = 1'b0;
		case (state_reg)
			ST_BOOT_SP: begin
				if (mem_ready) begin
					msp_next = mem_rdata;
					state_next = ST_BOOT_PC;
				end
			end
			ST_BOOT_PC: begin
				if (mem_ready) begin
					hpc_next = mem_rdata;
					hstart_next = 1'b1;
					state_next = ST_RUN;
				end
			end
			ST_RUN: begin
				if (ret_go) begin
					active_next[cur_reg] = 1'b0;
					if (tail_go) begin
						target_next = best_num;
						state_next = ST_VECTOR;
					end else begin
						// Thread frames may live on the process stack; handler frames never do.
						ret_thr_next = !stk_any;
						ret_psp_next = !stk_any && exc_return_psp;
						frame_next = (!stk_any && exc_return_psp) ? psp_reg : msp_reg;
						step_next = FRAME_FIRST;
						state_next = ST_UNSTACK;
					end
				end else if (preempt_go) begin
					target_next = best_num;
					frame_next = cur_sp - FRAME_BYTES;
					step_next = FRAME_FIRST;
					state_next = ST_STACK;
				end
			end
			ST_STACK: begin
				if (late_go)
					target_next = best_num;
				if (mem_ready) begin
					step_next = step_reg + 3'h1;
					if (last_word) begin
						if (sp_sel_reg)
							psp_next = frame_reg;
						else
							msp_next = frame_reg;
						state_next = ST_VECTOR;
					end
				end
			end
			ST_VECTOR: begin
				if (mem_ready) begin
					if (late_go) begin
						target_next = best_num;
					end else begin
						hpc_next = mem_rdata;
						hstart_next = 1'b1;
						active_next[target_reg] = 1'b1;
						cur_next = target_reg;
						hmode_next = 1'b1;
						sp_sel_next = 1'b0;
						state_next = ST_RUN;
					end
				end
			end
			ST_UNSTACK: begin
				if (mem_ready) begin
					if (slot == SLOT_PSW)
						cur_next = mem_rdata[NW-1:0];
					step_next = step_reg + 3'h1;
					if (last_word) begin
						if (ret_psp_reg)
							psp_next = frame_reg + FRAME_BYTES;
						else
							msp_next = frame_reg + FRAME_BYTES;
						hmode_next = !ret_thr_reg;
						sp_sel_next = ret_psp_reg;
						resume_next = 1'b1;
						state_next = ST_RUN;
					end
				end
			end
			default: state_next = ST_BOOT_SP;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= ST_BOOT_SP;
			{msp_reg, psp_reg, frame_reg, hpc_reg} <= '0;
			{cur_reg, target_reg, active_reg, step_reg} <= '0;
			{sp_sel_reg, hmode_reg, ret_psp_reg, ret_thr_reg, hstart_reg, resume_reg} <= '0;
		end else begin
			state_reg <= state_next;
			{msp_reg, psp_reg, frame_reg, hpc_reg} <= {msp_next, psp_next, frame_next, hpc_next};
			{cur_reg, target_reg, active_reg, step_reg} <=
				{cur_next, target_next, active_next, step_next};
			{sp_sel_reg, hmode_reg, ret_psp_reg, ret_thr_reg, hstart_reg, resume_reg} <=
				{sp_sel_next, hmode_next, ret_psp_next, ret_thr_next, hstart_next, resume_next};
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks.

	AST_PUSH_FIRST: assert property (@(posedge pclk) disable iff (!presetn)
		(state_reg == ST_RUN && state_next == ST_STACK) |=> (mem_we && core_reg_idx == SLOT_PC))
		else $error("first pushed word is not the program counter");
	AST_PUSH_SECOND: assert property (@(posedge pclk) disable iff (!presetn)
		(state_reg == ST_STACK && step_reg == FRAME_FIRST && mem_ready) |=> core_reg_idx == SLOT_PSW)
		else $error("second pushed word is not the status word");
	AST_STACK_SP: assert property (@(posedge pclk) disable iff (!presetn)
		(state_reg == ST_RUN && state_next == ST_STACK) |=> frame_reg == $past(cur_sp) - FRAME_BYTES)
		else $error("stack frame is not eight words below the stack pointer");
	AST_VEC_ADDR: assert property (@(posedge pclk) disable iff (!presetn)
		(state_reg == ST_VECTOR) |-> (mem_addr - vtor_reg) == 32'({target_reg, 2'h0}))
		else $error("vector fetch address is wrong");
	AST_LATE: assert property (@(posedge pclk) disable iff (!presetn)
		(state_reg == ST_STACK && late_go) |=> (target_reg == $past(best_num)
		&& (state_reg == ST_STACK || state_reg == ST_VECTOR)))
		else $error("late arrival did not retarget the vector fetch");
	AST_PREEMPT: assert property (@(posedge pclk) disable iff (!presetn)
		(state_reg == ST_RUN && !ret_go && preempt_go) |=> state_reg == ST_STACK)
		else $error("higher priority exception did not pre-empt");
	AST_TAIL: assert property (@(posedge pclk) disable iff (!presetn)
		(state_reg == ST_RUN && ret_go && tail_go) |=> state_reg == ST_VECTOR)
		else $error("tail-chain did not skip the frame");
	AST_UNSTACK_SP: assert property (@(posedge pclk) disable iff (!presetn)
		(state_reg == ST_UNSTACK && mem_ready && last_word) |=> cur_sp == $past(frame_reg) + FRAME_BYTES)
		else $error("stack pointer not raised by eight words");
	AST_HANDLER_MSP: assert property (@(posedge pclk) disable iff (!presetn)
		(handler_start && hmode_reg) |-> !sp_use_process)
		else $error("handler entered on the process stack");
	AST_RESUME: assert property (@(posedge pclk) disable iff (!presetn)
		(ctx_resume && !handler_mode) |-> active_reg == '0)
		else $error("thread resumed with exceptions still active");
	AST_PRI_LOW: assert property (@(posedge pclk) disable iff (!presetn)
		(setup_ph && !pwrite && hit_pri) |=> prdata[PRI_W-PRI_BITS-1:0] == PRI_PAD)
		else $error("unimplemented priority bits read nonzero");
endmodule : eeu_core

//--- testbench/eeu_far_side.sv
// Far side of the exception unit: core register file and a word memory.
// Assumes one clock; a word completes at an edge with mem_req and mem_ready high.
module eeu_far_side
	import eeu_pkg::*;
(
	input wire logic pclk,
	input wire logic slow,
	input wire logic [2:0] core_reg_idx,
	output logic [31:0] core_reg_rdata,
	input wire logic core_reg_we,
	input wire logic [31:0] core_reg_wdata,
	input wire logic [5:0] active_exc,
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic [31:0] mem_addr,
	input wire logic [31:0] mem_wdata,
	output logic [31:0] mem_rdata,
	output logic mem_ready
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] mem [logic [31:0]];
	logic [31:0] regs [0:7];
	logic [31:0] wr_addr [$];
	logic [31:0] wr_data [$];
	logic [31:0] junk = 32'h0000_0000;
	initial begin
		// Only the stack top is stored; other vector words follow an address pattern.
		mem[32'h0000_0000] = 32'h2000_0400;
		for (int i = 0; i < 8; i++) begin
			regs[i] = 32'hC0DE_0000 + 32'(i);
		end
	end
	// A slow memory answers every other cycle, so stacking stretches out.
	assign mem_ready = !slow || junk[0];
	assign core_reg_rdata = (core_reg_idx == SLOT_PSW) ? {26'h0, active_exc} : regs[core_reg_idx];
	always_comb begin
		if (mem_req && !mem_we) begin
			mem_rdata = mem.exists(mem_addr) ? mem[mem_addr] : {mem_addr[15:0] ^ 16'h5A5A, 16'h0};
		end else begin
			// Not read: show a value that changes every cycle, never the last word.
			mem_rdata = junk;
		end
	end
	always @(posedge pclk) begin
		junk <= junk + 32'h9E37_79B9;
		if (mem_req && mem_ready && mem_we) begin
			mem[mem_addr] = mem_wdata;
			wr_addr.push_back(mem_addr);
			wr_data.push_back(mem_wdata);
		end
		if (core_reg_we) begin
			regs[core_reg_idx] <= core_reg_wdata;
		end
	end
endmodule : eeu_far_side

//--- testbench/eeu_core_tb_top.sv
// Self-checking bench of the exception entry and exit unit.
// Assumes the far-side model holds the core registers and answers all memory words.
module eeu_core_tb_top;
	import eeu_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [31:0] SP0 = 32'h2000_0400;
	localparam logic [2:0] PUSH_ORD [8] = '{SLOT_PC, SLOT_PSW, SLOT_R0, SLOT_R1, SLOT_R2,
		SLOT_R3, SLOT_R12, SLOT_LINK};
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [47:0] exc_req = 48'h0;
	logic exc_return = 1'b0;
	logic exc_return_psp = 1'b0;
	logic [2:0] core_reg_idx;
	logic [31:0] core_reg_rdata;
	logic core_reg_we;
	logic [31:0] core_reg_wdata;
	logic core_stall;
	logic mem_req;
	logic mem_we;
	logic [31:0] mem_addr;
	logic [31:0] mem_wdata;
	logic [31:0] mem_rdata;
	logic mem_ready;
	logic handler_start;
	logic [31:0] handler_pc;
	logic ctx_resume;
	logic handler_mode;
	logic [5:0] active_exc;
	logic sp_use_process;
	logic [31:0] active_sp;
	logic pm_slow = 1'b0;
	logic hs;
	logic [31:0] rdv;
	logic errv;
	int error_cnt = 0;
	int n_compared = 0;

	eeu_core uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .exc_req(exc_req), .exc_return(exc_return),
		.exc_return_psp(exc_return_psp), .core_reg_idx(core_reg_idx),
		.core_reg_rdata(core_reg_rdata), .core_reg_we(core_reg_we),
		.core_reg_wdata(core_reg_wdata), .core_stall(core_stall), .mem_req(mem_req),
		.mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
		.mem_ready(mem_ready), .handler_start(handler_start), .handler_pc(handler_pc),
		.ctx_resume(ctx_resume), .handler_mode(handler_mode), .active_exc(active_exc),
		.sp_use_process(sp_use_process), .active_sp(active_sp));
	eeu_far_side pm (.pclk(pclk), .slow(pm_slow), .core_reg_idx(core_reg_idx),
		.core_reg_rdata(core_reg_rdata), .core_reg_we(core_reg_we),
		.core_reg_wdata(core_reg_wdata), .active_exc(active_exc), .mem_req(mem_req),
		.mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
		.mem_rdata(mem_rdata), .mem_ready(mem_ready));

	always #5 pclk = ~pclk;

	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] pat(input logic [31:0] a);
		return {a[15:0] ^ 16'h5A5A, 16'h0000};
	endfunction : pat

	task automatic print_verdict();
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : print_verdict

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	task automatic tmo();
		error_cnt++;
		$display("ERROR wait expected event seen timeout");
		print_verdict();
	endtask : tmo

	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) tmo();
		rdv = prdata;
		errv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	task automatic pri(input int n, input logic [7:0] v);
		apb(1'b1, OFF_PRI + 12'(4 * n), {24'h0, v});
	endtask : pri

	// Waits for a handler entry or a resume; one more edge lets all outputs land.
	task automatic wait_ev();
		int n;
		n = 0;
		while (handler_start !== 1'b1 && ctx_resume !== 1'b1) begin
			@(posedge pclk);
			n++;
			if (n > 400) tmo();
		end
		hs = handler_start;
		@(posedge pclk);
	endtask : wait_ev

	task automatic ret(input logic psp);
		exc_return <= 1'b1;
		exc_return_psp <= psp;
		@(posedge pclk);
		exc_return <= 1'b0;
		wait_ev();
	endtask : ret

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_boot();
		wait_ev();
		chk("boot pc", pat(VEC_RESET_OFF), handler_pc);
		chk("boot sp", SP0, active_sp);
		chk("boot mode", 32'h0, 32'(handler_mode));
		apb(1'b0, OFF_VTOR, 32'h0);
		chk("vtor reset", VTOR_RESET, rdv);
		apb(1'b0, OFF_MSP, 32'h0);
		chk("msp read", SP0, rdv);
		apb(1'b0, OFF_STAT, 32'h0);
		chk("stat read", 32'h0008_0000, rdv);
		pri(16, 8'hFF);
		apb(1'b0, OFF_PRI + 12'h040, 32'h0);
		chk("pri bits", 32'h0000_00E0, rdv);
		apb(1'b0, 12'hFFC, 32'h0);
		chk("unmapped err", 32'h1, 32'(errv));
		$display("done boot");
	endtask : t_boot

	task automatic t_nest();
		pri(16, 8'h00);
		pri(17, 8'hA0);
		pri(18, 8'h80);
		pri(19, 8'h80);
		pm.wr_addr.delete();
		pm.wr_data.delete();
		exc_req[17] <= 1'b1;
		wait_ev();
		for (int i = 0; i < 8; i++) begin
			chk("push addr", SP0 - FRAME_BYTES + 32'(4 * PUSH_ORD[i]), pm.wr_addr[i]);
			chk("push data", PUSH_ORD[i] == SLOT_PSW ? 32'h0 : 32'hC0DE_0000 + 32'(PUSH_ORD[i]),
				pm.wr_data[i]);
		end
		chk("entry sp", SP0 - FRAME_BYTES, active_sp);
		chk("entry pc", pat(32'(4 * 17)), handler_pc);
		// The handler clears its own request in the same cycle as request 18 rises.
		exc_req[18:17] <= 2'b10;
		wait_ev();
		chk("preempt", 32'd18, 32'(active_exc));
		exc_req[19] <= 1'b1;
		repeat (40) @(posedge pclk);
		chk("equal stays", 32'd18, 32'(active_exc));
		exc_req[18] <= 1'b0;
		ret(1'b0);
		chk("tail chain", 32'h8000_0013, {hs, 25'h0, active_exc});
		chk("tail no push", 32'd16, 32'(pm.wr_addr.size()));
		exc_req[19] <= 1'b0;
		ret(1'b0);
		chk("stacked exc", 32'd17, {hs, 25'h0, active_exc});
		chk("stacked sp", SP0 - FRAME_BYTES, active_sp);
		ret(1'b0);
		chk("thread state", 32'h0, {24'h0, handler_mode, sp_use_process, active_exc});
		chk("thread sp", SP0, active_sp);
		$display("done nest");
	endtask : t_nest

	task automatic t_group();
		for (int g = 0; g < 8; g++) begin
			apb(1'b1, OFF_CTRL, 32'(g));
			exc_req[17] <= 1'b1;
			wait_ev();
			exc_req[18:17] <= 2'b10;
			repeat (40) @(posedge pclk);
			chk("split", g <= 4 ? 32'd18 : 32'd17, 32'(active_exc));
			exc_req[18] <= 1'b0;
			if (g <= 4) ret(1'b0);
			ret(1'b0);
		end
		for (int k = 0; k < 2; k++) begin
			pri(17, k == 0 ? 8'hA0 : 8'h80);
			exc_req[18:17] <= 2'b11;
			wait_ev();
			chk("arbitrate", k == 0 ? 32'd18 : 32'd17, 32'(active_exc));
			exc_req[18:17] <= 2'b00;
			ret(1'b0);
		end
		$display("done group");
	endtask : t_group

	task automatic t_late();
		apb(1'b1, OFF_CTRL, 32'h0);
		pri(17, 8'hA0);
		pm.wr_addr.delete();
		pm_slow <= 1'b1;
		exc_req[17] <= 1'b1;
		repeat (4) @(posedge pclk);
		chk("stall stack", 32'h1, 32'(core_stall));
		exc_req[18] <= 1'b1;
		wait_ev();
		chk("stall run", 32'h0, 32'(core_stall));
		chk("late exc", 32'd18, 32'(active_exc));
		chk("late pushes", 32'd8, 32'(pm.wr_addr.size()));
		chk("late pc", pat(32'(4 * 18)), handler_pc);
		exc_req[18:17] <= 2'b00;
		pm_slow <= 1'b0;
		ret(1'b0);
		chk("late back", SP0, active_sp);
		$display("done late");
	endtask : t_late

	task automatic t_fault();
		int src [3] = '{2, 4, 4};
		int exn [3] = '{2, 3, 4};
		for (int k = 0; k < 3; k++) begin
			apb(1'b1, OFF_CTRL, k == 2 ? 32'h10 : 32'h0);
			exc_req <= 48'h1 << src[k];
			wait_ev();
			chk("fault exc", 32'(exn[k]), 32'(active_exc));
			chk("fault pc", pat(32'(4 * exn[k])), handler_pc);
			exc_req <= 48'h0;
			ret(1'b0);
		end
		$display("done fault");
	endtask : t_fault

	task automatic t_vtor();
		apb(1'b1, OFF_VTOR, 32'h2000_0000);
		apb(1'b0, OFF_VTOR, 32'h0);
		chk("vtor rw", 32'h2000_0000, rdv);
		exc_req[16] <= 1'b1;
		wait_ev();
		chk("moved pc", pat(32'h2000_0000 + VEC_EXT_OFF), handler_pc);
		exc_req[16] <= 1'b0;
		apb(1'b1, OFF_PSP, 32'h2000_0200);
		ret(1'b1);
		chk("psp select", 32'h1, 32'(sp_use_process));
		chk("psp pop", 32'h2000_0220, active_sp);
		$display("done vtor");
	endtask : t_vtor

	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		t_boot();
		t_nest();
		t_group();
		t_late();
		t_fault();
		t_vtor();
		print_verdict();
	end
endmodule : eeu_core_tb_top
